/* host_port_pkg.sv */
/*
 Shared constants and types for the host parallel port.
 Assumes a single 100 MHz clock and host pins sampled synchronously.
*/
package host_port_pkg;
	localparam int ADDR_WIDTH_DEF = 8;
	localparam int DATA_WIDTH_DEF = 8;
	localparam logic STYLE_RESET = 1'b0;
	localparam logic [7:0] READ_DATA_RESET = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b11
	} access_state_type;
endpackage

/* strobe_combine.sv */
/*
 Combines a host strobe with chip select and reports its edges.
 Assumes the inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
module strobe_combine (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_strobe_n,
	input  wire logic i_select_n,
	output logic      o_active,
	output logic      o_fall,
	output logic      o_rise
);
	logic active_reg;

	// Active only while both lines are low
	assign o_active = ~i_strobe_n & ~i_select_n;
	assign o_fall   = o_active & ~active_reg;
	assign o_rise   = ~o_active & active_reg;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= o_active;
		end
	end
endmodule // strobe_combine

/* ale_latch.sv */
/*
 Address latch for the multiplexed bus style.
 Assumes the address/data lines and the latch enable are synchronous to i_clk.
*/
`timescale 1ns/1ps
module ale_latch #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_ale,
	input  wire logic [ADDR_WIDTH-1:0] i_ad,
	output logic      [ADDR_WIDTH-1:0] o_addr,
	output logic                       o_ale_held
);
	logic                  ale_reg;
	logic [ADDR_WIDTH-1:0] addr_reg;

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			// Idles high like a demultiplexed host's ALE, so no false fall follows reset
			ale_reg  <= 1'b1;
			addr_reg <= '0;
		end else begin
			ale_reg <= i_ale;
			// Track while high, freeze on the falling edge
			if (i_ale) begin
				addr_reg <= i_ad;
			end
		end
	end

	assign o_addr     = addr_reg;
	assign o_ale_held = ale_reg;
endmodule // ale_latch

/* host_parallel_port.sv */
/*
 Host parallel slave port: the external host reads and writes internal
 registers over one of two bus styles chosen by a pin at reset.
 Assumes host pins are synchronous to i_clk; the register file sits outside
 and answers reads combinationally from o_reg_addr.
*/
// Operation
// - Style pin high: strobe/direction; low: split
// - Style captured at reset release, held
// - Strobe/direction style: demultiplexed buses only
// - Split style: ALE usage picks muxed/demuxed
// - Direction selects, data strobe times access
// - Access active while strobe and select low
// - Split style: read strobe reads, write writes
// - Muxed: address latched from shared lines
// - Muxed: address captured at ALE fall
// - Write data taken at strobe end
// - Read drives bus, floats after strobe end
`timescale 1ns/1ps
module host_parallel_port
	import host_port_pkg::*;
#(
	parameter int ADDR_WIDTH = ADDR_WIDTH_DEF,
	parameter int DATA_WIDTH = DATA_WIDTH_DEF
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_style_sel,
	input  wire logic                  i_select_n,
	input  wire logic [ADDR_WIDTH-1:0] i_addr,
	input  wire logic [DATA_WIDTH-1:0] i_data,
	input  wire logic                  i_data_strobe_n,
	input  wire logic                  i_read_write,
	input  wire logic                  i_read_n,
	input  wire logic                  i_write_n,
	input  wire logic                  i_ale,
	input  wire logic [DATA_WIDTH-1:0] i_reg_rdata,
	output logic      [DATA_WIDTH-1:0] o_data,
	output logic                       o_data_oe_n,
	output logic      [ADDR_WIDTH-1:0] o_reg_addr,
	output logic      [DATA_WIDTH-1:0] o_reg_wdata,
	output logic                       o_reg_write,
	output logic                       o_reg_read,
	output logic                       o_style_dir
);
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                  style_dir;
		logic                  style_taken;
		access_state_type      state;
		logic [ADDR_WIDTH-1:0] addr;
		logic [DATA_WIDTH-1:0] rdata;
		logic [DATA_WIDTH-1:0] wdata;
		logic                  drive;
		logic                  wr_pulse;
		logic                  rd_pulse;
	} port_state_type;

	port_state_type s_reg;
	port_state_type s_next;

	logic                  sd_fall, sd_rise;
	logic                  rd_fall, rd_rise;
	logic                  wr_fall, wr_rise;
	logic [ADDR_WIDTH-1:0] ale_addr;
	logic                  ale_held;
	logic                  muxed;
	logic [ADDR_WIDTH-1:0] cur_addr;
	logic                  acc_start, acc_end, acc_is_read;

	////////////////////////////////////////////////////////////////////////////
	strobe_combine u_sd (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_strobe_n (i_data_strobe_n),
		.i_select_n (i_select_n),
		.o_active   (),
		.o_fall     (sd_fall),
		.o_rise     (sd_rise)
	);

	strobe_combine u_rd (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_strobe_n (i_read_n),
		.i_select_n (i_select_n),
		.o_active   (),
		.o_fall     (rd_fall),
		.o_rise     (rd_rise)
	);

	strobe_combine u_wr (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_strobe_n (i_write_n),
		.i_select_n (i_select_n),
		.o_active   (),
		.o_fall     (wr_fall),
		.o_rise     (wr_rise)
	);

	// Multiplexed data lines carry the address; width taken from the low bits
	ale_latch #(.ADDR_WIDTH(ADDR_WIDTH)) u_ale (
		.i_clk      (i_clk),
		.i_nrst     (i_nrst),
		.i_ale      (i_ale),
		.i_ad       (ADDR_WIDTH'(i_data)),
		.o_addr     (ale_addr),
		.o_ale_held (ale_held)
	);

	////////////////////////////////////////////////////////////////////////////
	// A demultiplexed host keeps ALE high; in split style a low ALE during the strobe
	// means the address came over the data lines.
	assign muxed    = ~s_reg.style_dir & ~i_ale;
	assign cur_addr = muxed ? ale_addr : i_addr;

	always_comb begin
		if (s_reg.style_dir) begin
			acc_start   = sd_fall;
			acc_end     = sd_rise;
			acc_is_read = i_read_write;
		end else begin
			acc_start   = rd_fall | wr_fall;
			acc_end     = (s_reg.state == ST_READ) ? rd_rise : wr_rise;
			acc_is_read = rd_fall;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next          = s_reg;
		s_next.wr_pulse = 1'b0;
		s_next.rd_pulse = 1'b0;
		// Caught on the first clock after reset release
		if (!s_reg.style_taken) begin
			s_next.style_dir   = i_style_sel;
			s_next.style_taken = 1'b1;
		end else begin
			case (s_reg.state)
				ST_IDLE: begin
					if (acc_start) begin
						s_next.addr = cur_addr;
						if (acc_is_read) begin
							s_next.state    = ST_READ;
							s_next.rd_pulse = 1'b1;
						end else begin
							s_next.state = ST_WRITE;
						end
					end
				end
				ST_READ: begin
					// Sample register data one clock into the strobe
					s_next.rdata = i_reg_rdata;
					s_next.drive = 1'b1;
					if (acc_end) begin
						s_next.drive = 1'b0;
						s_next.state = ST_IDLE;
					end
				end
				ST_WRITE: begin
					s_next.wdata = i_data;
					s_next.addr  = cur_addr;
					if (acc_end) begin
						s_next.wr_pulse = 1'b1;
						s_next.state    = ST_IDLE;
					end
				end
				default: begin
					s_next.state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_reg <= '{style_dir: STYLE_RESET, style_taken: 1'b0, state: ST_IDLE,
				addr: '0, rdata: DATA_WIDTH'(READ_DATA_RESET), wdata: '0, drive: 1'b0,
				wr_pulse: 1'b0, rd_pulse: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_data      = s_reg.rdata;
	assign o_data_oe_n = ~s_reg.drive;
	assign o_reg_addr  = s_reg.addr;
	assign o_reg_wdata = s_reg.wdata;
	assign o_reg_write = s_reg.wr_pulse;
	assign o_reg_read  = s_reg.rd_pulse;
	assign o_style_dir = s_reg.style_dir;

	////////////////////////////////////////////////////////////////////////////
	style_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		s_reg.style_taken |=> $stable(s_reg.style_dir))
		else $error("bus style changed after reset");
	style_take_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!s_reg.style_taken |=> s_reg.style_dir == $past(i_style_sel))
		else $error("bus style not taken from pin");
	write_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(s_reg.state == ST_WRITE && acc_end) |=> o_reg_write && o_reg_wdata == $past(i_data))
		else $error("write not issued at strobe end");
	read_drive_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(s_reg.state == ST_IDLE && s_reg.style_taken && acc_start && acc_is_read)
		|=> ##1 !o_data_oe_n)
		else $error("read data not driven");
	read_float_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(s_reg.state == ST_READ && acc_end) |=> o_data_oe_n)
		else $error("data bus not released");
	drive_scope_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_data_oe_n |-> $past(s_reg.state) == ST_READ)
		else $error("bus driven outside read");
	dir_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(s_reg.style_dir && s_reg.state == ST_IDLE && sd_fall && i_read_write && s_reg.style_taken)
		|=> s_reg.state == ST_READ)
		else $error("direction high not read");
	dir_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(s_reg.style_dir && s_reg.state == ST_IDLE && sd_fall && !i_read_write && s_reg.style_taken)
		|=> s_reg.state == ST_WRITE)
		else $error("direction low not write");
	mux_addr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(ale_held && !i_ale && !s_reg.style_dir && s_reg.style_taken)
		|-> ale_addr == ADDR_WIDTH'($past(i_data)))
		else $error("address not latched at ale fall");
	addr_freeze_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!ale_held && !i_ale && s_reg.style_taken) |-> $stable(ale_addr))
		else $error("latched address moved while ale low");
	cov_read_c:  cover property (@(posedge i_clk) s_reg.state == ST_READ && acc_end);
	cov_write_c: cover property (@(posedge i_clk) o_reg_write);
	cov_mux_c:   cover property (@(posedge i_clk) muxed && o_reg_write);
	cov_dir_c:   cover property (@(posedge i_clk) s_reg.style_dir && o_reg_write);
endmodule // host_parallel_port

/* host_model.sv */
/*
 Host bus master model for the parallel port: drives address, select,
 strobes and latch enable. Assumes the bench calls start then finish.
*/
`timescale 1ns/1ps
module host_model (
	input  wire logic       i_clk,
	output logic            o_select_n = 1'b1,
	output logic      [7:0] o_addr = 8'h00,
	output logic      [7:0] o_data = 8'h00,
	output logic            o_data_strobe_n = 1'b1,
	output logic            o_read_write = 1'b1,
	output logic            o_read_n = 1'b1,
	output logic            o_write_n = 1'b1,
	output logic            o_ale = 1'b1
);
	task automatic start(input logic dir, input logic mux, input logic wr,
		input logic [7:0] a, input logic [7:0] d, input logic cs_n);
		@(negedge i_clk);
		o_select_n = cs_n;
		o_addr = a;
		o_read_write = ~wr;
		o_data = mux ? a : d;
		if (mux) begin
			@(negedge i_clk);
			o_ale = 1'b0;
			o_addr = ~a;
			o_data = d;
		end
		@(negedge i_clk);
		if (dir) o_data_strobe_n = 1'b0;
		else if (wr) o_write_n = 1'b0;
		else o_read_n = 1'b0;
	endtask

	// Data is inverted on release so a stale bus never looks valid
	task automatic finish();
		@(negedge i_clk);
		o_data_strobe_n = 1'b1;
		o_read_n = 1'b1;
		o_write_n = 1'b1;
		@(negedge i_clk);
		o_select_n = 1'b1;
		o_ale = 1'b1;
		o_data = ~o_data;
	endtask
endmodule // host_model

/* host_parallel_port_bench.sv */
/*
 Self-checking bench for the host parallel port.
 Assumes host_model drives the pins and reads return address xor 5a.
*/
`timescale 1ns/1ps
module host_parallel_port_bench;
	import host_port_pkg::*;
	logic       i_clk = 1'b0;
	logic       i_nrst = 1'b0;
	logic       i_style_sel = 1'b0;
	logic       i_select_n, i_data_strobe_n, i_read_write, i_read_n, i_write_n, i_ale;
	logic [7:0] i_addr, i_data, i_reg_rdata, o_data, o_reg_addr, o_reg_wdata;
	logic       o_data_oe_n, o_reg_write, o_reg_read, o_style_dir;
	logic [7:0] wr_addr, wr_data;
	int         n_wr = 0;
	int         n_rd = 0;
	int         n_mismatch = 0;
	int         cmp_count = 0;

	assign i_reg_rdata = o_reg_addr ^ 8'h5a;
	host_parallel_port host_parallel_port_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_style_sel(i_style_sel), .i_select_n(i_select_n), .i_addr(i_addr),
		.i_data(i_data), .i_data_strobe_n(i_data_strobe_n), .i_read_write(i_read_write),
		.i_read_n(i_read_n), .i_write_n(i_write_n), .i_ale(i_ale),
		.i_reg_rdata(i_reg_rdata), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
		.o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata), .o_reg_write(o_reg_write),
		.o_reg_read(o_reg_read), .o_style_dir(o_style_dir));
	host_model host_model_inst (.i_clk(i_clk), .o_select_n(i_select_n), .o_addr(i_addr),
		.o_data(i_data), .o_data_strobe_n(i_data_strobe_n), .o_read_write(i_read_write),
		.o_read_n(i_read_n), .o_write_n(i_write_n), .o_ale(i_ale));

	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// Pulses are counted here since their cycle varies with strobe length
	// Looked at on the falling edge, where the registered pulses have settled
	always @(negedge i_clk) begin
		if (o_reg_write === 1'b1) begin
			n_wr++;
			wr_addr = o_reg_addr;
			wr_data = o_reg_wdata;
		end
		if (o_reg_read === 1'b1) n_rd++;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reset_style(input logic s);
		i_nrst = 1'b0;
		i_style_sel = s;
		repeat (2) @(negedge i_clk);
		i_nrst = 1'b1;
		@(negedge i_clk);
		i_style_sel = ~s;
		@(negedge i_clk);
		check({7'h0, o_style_dir}, {7'h0, s});
	endtask

	task automatic do_write(input logic dir, input logic mux, input logic [7:0] a,
		input logic [7:0] d, input logic cs_n);
		int w0;
		w0 = n_wr;
		host_model_inst.start(dir, mux, 1'b1, a, d, cs_n);
		repeat (2) @(negedge i_clk);
		host_model_inst.finish();
		repeat (2) @(negedge i_clk);
		check(8'(n_wr - w0), {7'h0, ~cs_n});
		if (!cs_n) begin
			check(wr_addr, (dir && mux) ? ~a : a);
			check(wr_data, d);
		end
	endtask

	task automatic do_read(input logic dir, input logic mux, input logic [7:0] a);
		int r0;
		r0 = n_rd;
		host_model_inst.start(dir, mux, 1'b0, a, ~a, 1'b0);
		repeat (3) @(negedge i_clk);
		check({7'h0, o_data_oe_n}, 8'h00);
		check(o_data, a ^ 8'h5a);
		host_model_inst.finish();
		@(negedge i_clk);
		check({7'h0, o_data_oe_n}, 8'h01);
		check(8'(n_rd - r0), 8'h01);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset_style(1'b0);
		do_write(1'b0, 1'b0, 8'h3c, 8'ha5, 1'b0);
		do_read(1'b0, 1'b0, 8'h3c);
		do_write(1'b0, 1'b1, 8'h81, 8'h42, 1'b0);
		do_read(1'b0, 1'b1, 8'h81);
		do_write(1'b0, 1'b0, 8'h55, 8'h66, 1'b1);
		reset_style(1'b1);
		do_write(1'b1, 1'b0, 8'h17, 8'h99, 1'b0);
		do_read(1'b1, 1'b0, 8'h17);
		do_write(1'b1, 1'b1, 8'h24, 8'h3b, 1'b0);
		results();
	end

	// The whole sequence needs about 75 cycles
	initial begin
		repeat (2000) @(posedge i_clk);
		n_mismatch++;
		results();
	end
endmodule // host_parallel_port_bench
